//--- pkg/tdf_pkg.sv
// package for the transfer descriptor field block: offsets, layouts, reset values, carriers
package tdf_pkg;

	// word offsets on the wishbone slave (byte addresses, one aligned word each)
	localparam logic [4:0] OFF_ISO_TAIL = 5'h00; // isochronous tail word: count and valid
	localparam logic [4:0] OFF_INT_CTRL = 5'h04; // activation mask, frame, clear strobe
	localparam logic [4:0] OFF_INT_DW6 = 5'h08; // low half of interrupt dwords 7/6
	localparam logic [4:0] OFF_INT_DW7 = 5'h0c; // high half of interrupt dwords 7/6
	localparam logic [4:0] OFF_INT_DW4 = 5'h10; // low half of dwords 5/4: transaction status
	localparam logic [4:0] OFF_INT_DW5 = 5'h14; // high half of dwords 5/4: counts 2..0

	// isochronous tail word layout
	localparam int ISO_CNT_LSB = 3; // transfer byte count low bit
	localparam int ISO_CNT_MSB = 17; // transfer byte count high bit
	localparam int ISO_VALID_BIT = 0; // descriptor valid bit

	// interrupt control word layout
	localparam int CTRL_MASK_LSB = 0; // microframe activation mask, 8 bits
	localparam int CTRL_FRAME_LSB = 8; // descriptor frame number, 5 bits
	localparam int CTRL_CLEAR_BIT = 31; // write one to zero all counts and status

	// widths
	localparam int CNT_W = 12; // received byte count per microframe
	localparam int STS_W = 3; // transaction status per microframe
	localparam int XFER_W = 15; // transfer byte count, up to 32 kB less one byte
	localparam int FRAME_W = 5; // frame number compared against the engine's frame
	localparam int NUM_UF = 8; // microframes per frame

	// values after reset
	localparam logic [XFER_W-1:0] RST_XFER = 15'h0000;
	localparam logic RST_VALID = 1'b0;
	localparam logic [NUM_UF-1:0] RST_MASK = 8'h00;
	localparam logic [FRAME_W-1:0] RST_FRAME = 5'h00;
	localparam logic [CNT_W-1:0] RST_CNT = 12'h000;
	localparam logic [STS_W-1:0] RST_STS = 3'h0;

	// per-microframe result reported by the transaction engine
	typedef struct packed {
		logic valid; // one-cycle pulse: a result is offered
		logic [2:0] uframe; // microframe index 0..7
		logic [FRAME_W-1:0] frame; // frame number the result belongs to
		logic [CNT_W-1:0] count; // bytes received in that microframe
		logic [STS_W-1:0] status; // transaction status of that microframe
	} tdf_uf_result_t;

	// isochronous execution events from the engine
	typedef struct packed {
		logic done; // one-cycle pulse: whole descriptor executed
		logic fatal; // one-cycle pulse: fatal error during execution
	} tdf_iso_event_t;

endpackage : tdf_pkg

//--- hw/tdf_fields.sv
// descriptor field storage with a classic wishbone slave for software access
//
// Decided for this implementation: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps

// Notes on behaviour
// - transfer byte count sits in bits 17..3
// - count is buffer depth, max 32 kB minus 1
// - clear valid after whole descriptor executes
// - clear valid on fatal execution error too
// - store count only if mask set, frame matches
// - microframe 7 count in dword 7 bits 63..52
// - microframe 6 count in bits 51..40
// - microframe 5 count split over 39..28
// - microframes 4 and 3 in 27..16, 15..4
// - microframe 2 high nibble in bits 3..0
// - microframe 2 low byte in dword 5 63..56
// - each microframe status, seven in 31..29
module tdf_fields (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// engine side
	input wire tdf_pkg::tdf_iso_event_t iso_evt_i,
	input wire tdf_pkg::tdf_uf_result_t uf_res_i,
	// descriptor state towards the engine
	output logic iso_valid_o,
	output logic [tdf_pkg::XFER_W-1:0] iso_byte_count_o,
	output logic [tdf_pkg::NUM_UF-1:0] uf_activation_mask_o,
	output logic [tdf_pkg::FRAME_W-1:0] uf_frame_o
);

	// all state of the block in one record
	typedef struct packed {
		logic [tdf_pkg::XFER_W-1:0] xfer; // transfer byte count
		logic valid; // descriptor valid bit
		logic [tdf_pkg::NUM_UF-1:0] mask; // microframe activation mask
		logic [tdf_pkg::FRAME_W-1:0] frame; // frame the descriptor is meant for
		logic [tdf_pkg::NUM_UF-1:0][tdf_pkg::CNT_W-1:0] cnt; // received counts
		logic [tdf_pkg::NUM_UF-1:0][tdf_pkg::STS_W-1:0] sts; // transaction status
		logic ack; // wishbone acknowledge
		logic [31:0] rdat; // registered read data
	} tdf_state_t;

	tdf_state_t st; // current state
	tdf_state_t next_st; // value for the next edge

	// bus decode terms
	logic bus_req; // a fresh request that has not been acknowledged yet
	logic bus_wr; // write that takes effect at this edge's ack
	logic uf_take; // engine result passes the mask and frame gate
	logic [63:0] int_dw76; // interrupt dwords 7 and 6 as one 64-bit word
	logic [63:0] int_dw54; // interrupt dwords 5 and 4 as one 64-bit word
	logic [31:0] iso_word; // isochronous tail word as read back
	logic [31:0] ctrl_word; // control word as read back
	logic [31:0] rd_mux; // read data selected by address

	// byte-lane merge so partial writes leave other lanes alone
	function automatic logic [31:0] lane_merge(input logic [31:0] old_w, input logic [31:0] new_w,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old_w;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = new_w[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// request is answered one cycle after it appears; ack drops the cycle after
	assign bus_req = wb_cyc_i && wb_stb_i && !st.ack;
	assign bus_wr = bus_req && wb_we_i;

	// a result only counts when its microframe is enabled and the frame agrees
	assign uf_take = uf_res_i.valid && st.mask[uf_res_i.uframe]
		&& (uf_res_i.frame == st.frame);

	// packing of the interrupt count fields: 12+12+12+12+12+4 bits fill dwords 7/6
	assign int_dw76 = {st.cnt[7],
		st.cnt[6],
		st.cnt[5],
		st.cnt[4], st.cnt[3],
		st.cnt[2][11:8]};

	// dwords 5/4: low byte of microframe 2, counts 1 and 0, then eight status fields
	assign int_dw54 = {st.cnt[2][7:0],
		st.cnt[1], st.cnt[0],
		st.sts[7], st.sts[6], st.sts[5], st.sts[4],
		st.sts[3], st.sts[2], st.sts[1], st.sts[0], 8'h00};

	// field bounds as local constants so part-selects stay static
	localparam int ISO_CNT_MSB_L = tdf_pkg::ISO_CNT_MSB;
	localparam int ISO_CNT_LSB_L = tdf_pkg::ISO_CNT_LSB;

	// read-back views of the software words; reserved bits read as zero
	always_comb begin
		iso_word = 32'h0000_0000;
		iso_word[ISO_CNT_MSB_L:ISO_CNT_LSB_L] = st.xfer;
		iso_word[tdf_pkg::ISO_VALID_BIT] = st.valid;
		ctrl_word = 32'h0000_0000;
		ctrl_word[tdf_pkg::CTRL_MASK_LSB +: tdf_pkg::NUM_UF] = st.mask;
		ctrl_word[tdf_pkg::CTRL_FRAME_LSB +: tdf_pkg::FRAME_W] = st.frame;
	end

	// address decode for reads; unmapped words answer with zero
	always_comb begin
		unique case (wb_adr_i)
			tdf_pkg::OFF_ISO_TAIL: rd_mux = iso_word;
			tdf_pkg::OFF_INT_CTRL: rd_mux = ctrl_word;
			tdf_pkg::OFF_INT_DW6: rd_mux = int_dw76[31:0];
			tdf_pkg::OFF_INT_DW7: rd_mux = int_dw76[63:32];
			tdf_pkg::OFF_INT_DW4: rd_mux = int_dw54[31:0];
			tdf_pkg::OFF_INT_DW5: rd_mux = int_dw54[63:32];
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// next-state logic for the whole block
	always_comb begin
		logic [31:0] merged;
		merged = 32'h0000_0000;
		next_st = st;
		// acknowledge is a single-cycle pulse per request
		next_st.ack = bus_req;
		next_st.rdat = bus_req ? rd_mux : st.rdat;

		// hardware clears valid when the descriptor retires or hits a fatal error
		if (iso_evt_i.done) begin
			next_st.valid = 1'b0;
		end
		if (iso_evt_i.fatal) begin
			next_st.valid = 1'b0;
		end

		// software writes follow the hardware clears, so a new activation beats a
		// same-cycle retire, but only when the write really carries the valid lane
		if (bus_wr) begin
			unique case (wb_adr_i)
				tdf_pkg::OFF_ISO_TAIL: begin
					merged = lane_merge(iso_word, wb_dat_i, wb_sel_i);
					// 15 bits cannot exceed 32 kB less one byte
					next_st.xfer = merged[ISO_CNT_MSB_L:ISO_CNT_LSB_L];
					// without lane 0 the merged bit is just the old valid, which would
					// undo a hardware clear landing in this very cycle
					if (wb_sel_i[0]) begin
						next_st.valid = merged[tdf_pkg::ISO_VALID_BIT];
					end
				end
				tdf_pkg::OFF_INT_CTRL: begin
					merged = lane_merge(ctrl_word, wb_dat_i, wb_sel_i);
					next_st.mask = merged[tdf_pkg::CTRL_MASK_LSB +: tdf_pkg::NUM_UF];
					next_st.frame = merged[tdf_pkg::CTRL_FRAME_LSB +: tdf_pkg::FRAME_W];
					// clear strobe zeroes all counts and status; a same-cycle result still lands
					if (wb_sel_i[3] && wb_dat_i[tdf_pkg::CTRL_CLEAR_BIT]) begin
						for (int u = 0; u < tdf_pkg::NUM_UF; u++) begin
							next_st.cnt[u] = tdf_pkg::RST_CNT;
							next_st.sts[u] = tdf_pkg::RST_STS;
						end
					end
				end
				default: begin
					// result words are read-only; other offsets ignore writes
					merged = 32'h0000_0000;
				end
			endcase
		end

		// engine results go last: a count reported while software clears would
		// otherwise be lost, and the engine never repeats a microframe's result
		if (uf_take) begin
			next_st.cnt[uf_res_i.uframe] = uf_res_i.count;
			next_st.sts[uf_res_i.uframe] = uf_res_i.status;
		end // a rejected result falls through untouched
	end

	// state register with synchronous reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st.xfer <= tdf_pkg::RST_XFER;
			st.valid <= tdf_pkg::RST_VALID;
			st.mask <= tdf_pkg::RST_MASK;
			st.frame <= tdf_pkg::RST_FRAME;
			for (int u = 0; u < tdf_pkg::NUM_UF; u++) begin
				st.cnt[u] <= tdf_pkg::RST_CNT;
				st.sts[u] <= tdf_pkg::RST_STS;
			end
			st.ack <= 1'b0;
			st.rdat <= 32'h0000_0000;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from flip-flops
	assign wb_ack_o = st.ack;
	assign wb_dat_o = st.rdat;
	assign iso_valid_o = st.valid;
	assign iso_byte_count_o = st.xfer;
	assign uf_activation_mask_o = st.mask;
	assign uf_frame_o = st.frame;

	// checks on the block's own behaviour
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// helper: a write to the tail word that touches the low byte
	logic iso_wr_lo;
	assign iso_wr_lo = bus_wr && (wb_adr_i == tdf_pkg::OFF_ISO_TAIL) && wb_sel_i[0];

	// helper: a read of a given word being answered
	logic rd_dw7, rd_dw6, rd_dw5, rd_dw4;
	assign rd_dw7 = bus_req && !wb_we_i && (wb_adr_i == tdf_pkg::OFF_INT_DW7);
	assign rd_dw6 = bus_req && !wb_we_i && (wb_adr_i == tdf_pkg::OFF_INT_DW6);
	assign rd_dw5 = bus_req && !wb_we_i && (wb_adr_i == tdf_pkg::OFF_INT_DW5);
	assign rd_dw4 = bus_req && !wb_we_i && (wb_adr_i == tdf_pkg::OFF_INT_DW4);

	// helper: control word writes, and the clear strobe among them
	logic ctrl_wr;
	logic ctrl_clr;
	assign ctrl_wr = bus_wr && (wb_adr_i == tdf_pkg::OFF_INT_CTRL);
	assign ctrl_clr = ctrl_wr && wb_sel_i[3] && wb_dat_i[tdf_pkg::CTRL_CLEAR_BIT];

	a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acknowledged next cycle");

	a_xfer_written: assert property (
		iso_wr_lo && wb_sel_i[1] && wb_sel_i[2]
		|=> iso_byte_count_o == $past(wb_dat_i[17:3]))
		else $error("transfer byte count not taken from bits 17..3");

	a_valid_retire: assert property (
		iso_evt_i.done && !iso_wr_lo |=> !iso_valid_o)
		else $error("valid still set after descriptor retired");

	a_valid_fatal: assert property (
		iso_evt_i.fatal && !iso_wr_lo |=> !iso_valid_o)
		else $error("valid still set after fatal error");

	a_valid_set: assert property (
		iso_wr_lo && wb_dat_i[0] |=> iso_valid_o)
		else $error("software set of valid lost");

	a_count_taken: assert property (
		uf_res_i.valid && uf_activation_mask_o[uf_res_i.uframe]
		&& uf_res_i.frame == uf_frame_o && !bus_wr
		|=> st.cnt[$past(uf_res_i.uframe)] == $past(uf_res_i.count))
		else $error("enabled microframe count not recorded");

	a_count_gated: assert property (
		!uf_take && !bus_wr |=> $stable(st.cnt) && $stable(st.sts))
		else $error("gated-off microframe changed a field");

	a_dw7_map: assert property (
		rd_dw7 |=> wb_dat_o[31:20] == $past(st.cnt[7]) && wb_dat_o[19:8] == $past(st.cnt[6]))
		else $error("microframe 7 or 6 count misplaced in dword 7");

	a_dw7_split: assert property (
		rd_dw7 ##0 rd_dw7 |=> wb_dat_o[7:0] == $past(st.cnt[5][11:4]))
		else $error("microframe 5 high bits misplaced");

	a_dw6_map: assert property (
		rd_dw6 |=> wb_dat_o[31:28] == $past(st.cnt[5][3:0])
		&& wb_dat_o[27:16] == $past(st.cnt[4]) && wb_dat_o[15:4] == $past(st.cnt[3])
		&& wb_dat_o[3:0] == $past(st.cnt[2][11:8]))
		else $error("dword 6 counts misplaced");

	a_dw5_map: assert property (
		rd_dw5 |=> wb_dat_o[31:24] == $past(st.cnt[2][7:0]))
		else $error("microframe 2 low byte misplaced in dword 5");

	a_dw4_status: assert property (
		rd_dw4 |=> wb_dat_o[31:29] == $past(st.sts[7]) && wb_dat_o[7:0] == 8'h00)
		else $error("microframe 7 status misplaced");

	// read-back placement of microframe 1 and 0 counts, plus repeats of two dword 7 and dword 6 checks above
	a_dw7_mf6: assert property (
		rd_dw7 |=> wb_dat_o[19:8] == $past(st.cnt[6]))
		else $error("microframe 6 count misplaced in dword 7");

	a_dw6_high: assert property (
		rd_dw6 |=> wb_dat_o[3:0] == $past(st.cnt[2][11:8]))
		else $error("microframe 2 high bits misplaced in dword 6");

	a_dw5_low: assert property (
		rd_dw5 |=> wb_dat_o[23:12] == $past(st.cnt[1])
		&& wb_dat_o[11:0] == $past(st.cnt[0]))
		else $error("microframe 1 or 0 count misplaced in dword 5");

	// hardware write gate, including its race with the software clear strobe
	a_status_taken: assert property (
		uf_take
		|=> st.sts[$past(uf_res_i.uframe)] == $past(uf_res_i.status))
		else $error("enabled microframe status not recorded");

	a_result_beats_clear: assert property (
		uf_take && ctrl_clr |=> st.cnt[$past(uf_res_i.uframe)] == $past(uf_res_i.count))
		else $error("result lost to a same-cycle clear");

	a_ro_ignored: assert property (
		bus_wr && wb_adr_i != tdf_pkg::OFF_INT_CTRL && !uf_take
		|=> $stable(st.cnt) && $stable(st.sts))
		else $error("write to a result word changed a field");

	// fields that only software, or the retire events, may change
	a_valid_hold: assert property (
		!iso_evt_i.done && !iso_evt_i.fatal && !iso_wr_lo |=> $stable(iso_valid_o))
		else $error("valid changed with no write and no event");

	a_xfer_hold: assert property (
		!(bus_wr && wb_adr_i == tdf_pkg::OFF_ISO_TAIL) |=> $stable(iso_byte_count_o))
		else $error("transfer byte count changed with no write");

	a_mask_written: assert property (
		ctrl_wr && wb_sel_i[0] |=> uf_activation_mask_o == $past(wb_dat_i[7:0]))
		else $error("activation mask not taken from the write");

	a_frame_written: assert property (
		ctrl_wr && wb_sel_i[1] |=> uf_frame_o == $past(wb_dat_i[12:8]))
		else $error("frame number not taken from the write");

	a_rdat_hold: assert property (!bus_req |=> $stable(wb_dat_o))
		else $error("read data moved with no request");

	// main scenarios worth seeing
	c_retire: cover property (iso_valid_o ##1 iso_evt_i.done ##1 !iso_valid_o);
	c_fatal: cover property (iso_valid_o && iso_evt_i.fatal);
	c_take: cover property (uf_take && uf_res_i.uframe == 3'h7);
	c_reject: cover property (uf_res_i.valid && !uf_take);
	c_clear_race: cover property (uf_take && ctrl_clr);

endmodule // tdf_fields

//--- tb/tdf_engine_model.sv
// behavioural transaction engine: offers microframe results and execution events
`timescale 1ns/1ps
module tdf_engine_model (
	// clock
	input wire logic clk_i,
	// towards the block
	output tdf_pkg::tdf_uf_result_t uf_res_o,
	output tdf_pkg::tdf_iso_event_t iso_evt_o
);
	// quiet at time zero
	initial begin
		uf_res_o = '0;
		iso_evt_o = '0;
	end
	// offer one result; calls may follow each other edge by edge
	task put(input logic [2:0] u, input logic [4:0] f, input logic [11:0] c, input logic [2:0] s);
		@(posedge clk_i);
		uf_res_o <= {1'b1, u, f, c, s};
	endtask
	// drop valid and invert the data, so a stale result never looks current
	task idle();
		@(posedge clk_i);
		uf_res_o <= {1'b0, ~uf_res_o[22:0]};
	endtask
	// one-cycle pulse of done or fatal
	task pulse(input logic d, input logic f);
		@(posedge clk_i);
		iso_evt_o <= {d, f};
		@(posedge clk_i);
		iso_evt_o <= '0;
	endtask
endmodule // tdf_engine_model

//--- tb/tb_tdf_fields.sv
// self-checking bench for the descriptor field block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_mismatch++; \
	$display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module tb_tdf_fields;
	logic clk_i = 1'b0; // 100 MHz
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [4:0] wb_adr_i = 5'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	tdf_pkg::tdf_iso_event_t iso_evt;
	tdf_pkg::tdf_uf_result_t uf_res;
	logic iso_valid_o;
	logic [14:0] iso_byte_count_o;
	logic [7:0] uf_activation_mask_o;
	logic [4:0] uf_frame_o;
	int n_mismatch = 0;
	int checked = 0;
	logic [11:0] cnt [8]; // expected counts per microframe
	logic [2:0] sts [8]; // expected status per microframe
	logic [31:0] rd;
	// clock
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	tdf_fields dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .iso_evt_i(iso_evt), .uf_res_i(uf_res),
		.iso_valid_o(iso_valid_o), .iso_byte_count_o(iso_byte_count_o),
		.uf_activation_mask_o(uf_activation_mask_o), .uf_frame_o(uf_frame_o));
	tdf_engine_model eng (.clk_i(clk_i), .uf_res_o(uf_res), .iso_evt_o(iso_evt));
	// classic single cycle; held until ack is sampled high, bounded wait
	task wbs(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) n_mismatch++;
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	// full-word access
	task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
		wbs(w, a, d, 4'hf);
	endtask
	// read back all four interrupt words against the expected arrays
	task chk_words();
		wb(1'b0, 5'h0c, 32'h0);
		`CHK("dw7", {cnt[7], cnt[6], cnt[5][11:4]}, rd)
		wb(1'b0, 5'h08, 32'h0);
		`CHK("dw6", {cnt[5][3:0], cnt[4], cnt[3], cnt[2][11:8]}, rd)
		wb(1'b0, 5'h14, 32'h0);
		`CHK("dw5", {cnt[2][7:0], cnt[1], cnt[0]}, rd)
		wb(1'b0, 5'h10, 32'h0);
		`CHK("dw4", {sts[7], sts[6], sts[5], sts[4], sts[3], sts[2], sts[1], sts[0], 8'h00}, rd)
	endtask
	// every word, and one unmapped place, reads zero after reset
	task t_reset();
		for (int a = 0; a < 7; a++) begin
			wb(1'b0, 5'(a * 4), 32'h0);
			`CHK("reset word", 32'h0, rd)
		end
	endtask
	// largest count with valid; hardware clears valid on done and on fatal
	task t_iso();
		wb(1'b1, 5'h00, 32'h0003fff9);
		@(negedge clk_i);
		`CHK("count", 15'h7fff, iso_byte_count_o)
		`CHK("valid set", 1'b1, iso_valid_o)
		eng.pulse(1'b1, 1'b0);
		@(negedge clk_i);
		`CHK("valid done", 1'b0, iso_valid_o)
		wb(1'b0, 5'h00, 32'h0);
		`CHK("tail", 32'h0003fff8, rd)
		wb(1'b1, 5'h00, 32'h00000009);
		eng.pulse(1'b0, 1'b1);
		@(negedge clk_i);
		`CHK("valid fatal", 1'b0, iso_valid_o)
	endtask
	// back-to-back results, then gated ones, a read-only write and the clear
	task t_counts();
		wb(1'b1, 5'h04, 32'h00000aff);
		`CHK("mask", 8'hff, uf_activation_mask_o)
		`CHK("frame", 5'h0a, uf_frame_o)
		for (int u = 0; u < 8; u++) begin
			cnt[u] = 12'h5a1 + 12'(u * 12'h213);
			sts[u] = 3'(u) ^ 3'h5;
			eng.put(3'(u), 5'h0a, cnt[u], sts[u]);
		end
		eng.idle();
		chk_words();
		// microframe 3 masked, microframe 7 in the wrong frame: both must keep old fields
		wb(1'b1, 5'h04, 32'h00000af7);
		eng.put(3'h3, 5'h0a, 12'hfff, 3'h7);
		eng.put(3'h7, 5'h0b, 12'heee, 3'h0);
		eng.put(3'h1, 5'h0a, 12'h0c3, 3'h2);
		eng.idle();
		cnt[1] = 12'h0c3;
		sts[1] = 3'h2;
		wb(1'b1, 5'h08, 32'hffffffff);
		chk_words();
		wb(1'b1, 5'h04, 32'h80000000);
		for (int u = 0; u < 8; u++) begin
			cnt[u] = 12'h000;
			sts[u] = 3'h0;
		end
		chk_words();
	endtask
	// partial lanes, a retire racing a count write, a result racing the clear
	task t_lanes();
		wb(1'b1, 5'h00, 32'h00000001);
		fork
			wbs(1'b1, 5'h00, 32'h00012300, 4'h6);
			eng.pulse(1'b1, 1'b0);
		join
		@(negedge clk_i);
		`CHK("lane count", 15'h2460, iso_byte_count_o)
		`CHK("lane retire", 1'b0, iso_valid_o)
		wb(1'b1, 5'h00, 32'h00000001);
		wbs(1'b1, 5'h00, 32'h00000000, 4'h6);
		@(negedge clk_i);
		`CHK("lane keep", 1'b1, iso_valid_o)
		// clear bit sits in lane 3, so leaving that lane out must not clear
		wbs(1'b1, 5'h04, 32'h80000aff, 4'h7);
		eng.put(3'h2, 5'h0a, 12'habc, 3'h3);
		eng.idle();
		cnt[2] = 12'habc;
		sts[2] = 3'h3;
		wbs(1'b1, 5'h04, 32'h80000aff, 4'h7);
		chk_words();
		fork
			wbs(1'b1, 5'h04, 32'h80000aff, 4'hf);
			begin
				eng.put(3'h5, 5'h0a, 12'h3c5, 3'h6);
				eng.idle();
			end
		join
		foreach (cnt[u]) begin
			cnt[u] = (u == 5) ? 12'h3c5 : 12'h000;
			sts[u] = (u == 5) ? 3'h6 : 3'h0;
		end
		chk_words();
	endtask
	// verdict and end of run
	task results();
		if (n_mismatch == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_iso();
		t_counts();
		t_lanes();
		results();
	end
	// watchdog, far beyond the roughly 160 cycles the tests need
	initial begin
		repeat (5000) @(posedge clk_i);
		n_mismatch++;
		results();
	end
endmodule // tb_tdf_fields
